// ==== core/tec_event_counter.sv ====
// The APB slave port and the register addresses were left to the implementer.
`include "tec_defines.svh"
module tec_event_counter
  import tec_pkg::*;
#(
  parameter int CHANNEL = 2
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Count sources
  input wire logic count_input_pin,
  input wire logic timer_b2_ovf,
  input wire logic neighbour_timer_channel_ovf,
  // Output pin, doubling as direction input
  input wire logic pulse_output_pin_in,
  output logic pulse_output_pin_out,
  output logic pulse_output_pin_oe,
  // Events
  output logic overflow_pulse,
  output logic irq
);
  localparam bit TWO_PHASE_OK = (CHANNEL >= 2);

  tec_state_t s_r;
  tec_state_t s_nxt;
  logic ovf_r;
  logic pin_out_r;
  logic pin_oe_r;
  logic pin_out_nxt;
  logic pin_oe_nxt;

  logic wr;
  logic rd;
  logic in_level;
  logic dir_ext_down;
  logic edge_hit;
  logic tick;
  logic down;
  logic running;
  logic wrap;

  assign wr = psel && penable && pwrite && s_r.pready;
  assign rd = psel && !penable && !pwrite;

  always_comb begin
    in_level = s_r.in_sync[2];
    dir_ext_down = s_r.dir_sync[2];
    running = s_r.ctrl[`TEC_CTRL_START];
    // Edge counted once stages two and three agree on the new level
    edge_hit = (s_r.in_sync[1] == s_r.in_sync[2]) && (in_level != s_r.in_prev) &&
      (in_level == !s_r.ctrl[`TEC_CTRL_EDGE]) && s_r.ctrl[`TEC_CTRL_IN_COUNT];
    unique case (tec_src_t'(s_r.ctrl[`TEC_CTRL_SRC_HI:`TEC_CTRL_SRC_LO]))
      TEC_SRC_PIN: tick = edge_hit;
      TEC_SRC_TB2: tick = timer_b2_ovf;
      TEC_SRC_NEIGH: tick = neighbour_timer_channel_ovf;
      default: tick = 1'b0;
    endcase
    down = s_r.ctrl[`TEC_CTRL_DIR_EXT] ? dir_ext_down : s_r.ctrl[`TEC_CTRL_DIR_DOWN];
    wrap = running && tick && (down ? (s_r.count == 16'h0000) :
      (s_r.count == 16'hffff));
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.in_sync = {s_r.in_sync[1:0], count_input_pin};
    s_nxt.dir_sync = {s_r.dir_sync[1:0], pulse_output_pin_in};
    if (s_r.in_sync[1] == s_r.in_sync[2]) begin
      s_nxt.in_prev = in_level;
    end
    if (running && tick) begin
      if (wrap && !s_r.ctrl[`TEC_CTRL_FREERUN]) begin
        s_nxt.count = s_r.reload;
      end else if (down) begin
        s_nxt.count = s_r.count - 16'h0001;
      end else begin
        s_nxt.count = s_r.count + 16'h0001;
      end
    end
    if (wrap && !down && s_r.ctrl[`TEC_CTRL_PULSE]) begin
      s_nxt.pulse = !s_r.pulse;
    end
    s_nxt.pready = psel && !penable;
    if (wr) begin
      unique case (paddr)
        `TEC_OFF_CTRL: begin
          s_nxt.ctrl = pwdata[`TEC_CTRL_W-1:0];
          s_nxt.ctrl[`TEC_CTRL_TWO_PHASE] = pwdata[`TEC_CTRL_TWO_PHASE] && TWO_PHASE_OK;
        end
        `TEC_OFF_TIMER: begin
          s_nxt.reload = pwdata[15:0];
          if (!running) begin
            s_nxt.count = pwdata[15:0];
          end
        end
        `TEC_OFF_STATUS: s_nxt.status = s_r.status & ~pwdata[1:0];
        `TEC_OFF_MASK: s_nxt.mask = pwdata[1:0];
        `TEC_OFF_PORT: begin
          s_nxt.port_out = pwdata[0];
          s_nxt.port_oe = pwdata[1];
        end
        default: ;
      endcase
    end
    // Set wins over a same-cycle clear
    if (wrap && !down) begin
      s_nxt.status[`TEC_ST_OVF] = 1'b1;
    end
    if (wrap && down) begin
      s_nxt.status[`TEC_ST_UNF] = 1'b1;
    end
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
    if (rd) begin
      unique case (paddr)
        `TEC_OFF_CTRL: s_nxt.prdata = {22'h0, s_r.ctrl};
        `TEC_OFF_TIMER: s_nxt.prdata = {16'h0, s_r.count};
        `TEC_OFF_STATUS: s_nxt.prdata = {30'h0, s_r.status};
        `TEC_OFF_MASK: s_nxt.prdata = {30'h0, s_r.mask};
        `TEC_OFF_PORT: s_nxt.prdata = {29'h0, in_level, s_r.port_oe, s_r.port_out};
        default: s_nxt.prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.ctrl <= `TEC_CTRL_RST;
      s_r.count <= `TEC_TIMER_RST;
      s_r.reload <= `TEC_TIMER_RST;
      ovf_r <= 1'b0;
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      s_r <= s_nxt;
      ovf_r <= wrap;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  always_comb begin
    prdata = s_r.prdata;
    pready = s_r.pready;
    pslverr = 1'b0;
    irq = s_r.irq;
    overflow_pulse = ovf_r;
    pulse_output_pin_out = pin_out_r;
    pulse_output_pin_oe = pin_oe_r;
  end

  // Pin select: pulse output, direction input or general I/O
  always_comb begin
    if (s_r.ctrl[`TEC_CTRL_PULSE]) begin
      pin_out_nxt = s_r.pulse;
      pin_oe_nxt = 1'b1;
    end else if (s_r.ctrl[`TEC_CTRL_DIR_EXT]) begin
      pin_out_nxt = 1'b0;
      pin_oe_nxt = 1'b0;
    end else begin
      pin_out_nxt = s_r.port_out;
      pin_oe_nxt = s_r.port_oe;
    end
  end

  a_reload_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    wrap && !s_r.ctrl[`TEC_CTRL_FREERUN] |=> s_r.count == $past(s_r.reload))
    else $error("count not reloaded on wrap");
  a_freerun_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    wrap && s_r.ctrl[`TEC_CTRL_FREERUN] && !down |=> s_r.count == 16'h0000)
    else $error("free-run up wrap not to zero");
  a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !running && !wr |=> s_r.count == $past(s_r.count))
    else $error("count moved while stopped");
  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    wrap && !down && s_r.mask[`TEC_ST_OVF] |=> irq)
    else $error("overflow gave no irq");
  a_write_stopped: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `TEC_OFF_TIMER && !running |=> s_r.count == $past(pwdata[15:0]))
    else $error("stopped write missed counter");
  a_write_running: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `TEC_OFF_TIMER && running && !tick |=>
      s_r.count == $past(s_r.count) && s_r.reload == $past(pwdata[15:0]))
    else $error("running write touched counter");
  a_pulse_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    wrap && !down && s_r.ctrl[`TEC_CTRL_PULSE] |=> s_r.pulse != $past(s_r.pulse))
    else $error("pulse output did not invert");
  a_read_count: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == `TEC_OFF_TIMER |=> prdata[15:0] == $past(s_r.count))
    else $error("read did not return count");
  a_up_step: assert property (@(posedge pclk) disable iff (!presetn)
    running && tick && !down && !wrap && !wr |=> s_r.count == $past(s_r.count) + 16'h0001)
    else $error("up count step wrong");
endmodule : tec_event_counter

// ==== core/tec_defines.svh ====
`ifndef TEC_DEFINES_SVH
`define TEC_DEFINES_SVH
`define TEC_OFF_CTRL 12'h000
`define TEC_OFF_TIMER 12'h004
`define TEC_OFF_STATUS 12'h008
`define TEC_OFF_MASK 12'h00c
`define TEC_OFF_PORT 12'h010
// Control bit positions
`define TEC_CTRL_START 0
`define TEC_CTRL_EDGE 1
`define TEC_CTRL_SRC_LO 2
`define TEC_CTRL_SRC_HI 3
`define TEC_CTRL_DIR_EXT 4
`define TEC_CTRL_DIR_DOWN 5
`define TEC_CTRL_FREERUN 6
`define TEC_CTRL_PULSE 7
`define TEC_CTRL_IN_COUNT 8
`define TEC_CTRL_TWO_PHASE 9
`define TEC_CTRL_W 10
`define TEC_CTRL_RST 10'h000
// Status bit positions
`define TEC_ST_OVF 0
`define TEC_ST_UNF 1
`define TEC_TIMER_RST 16'hffff
`endif

// ==== core/tec_pkg.sv ====
package tec_pkg;
  typedef enum logic [1:0] {
    TEC_SRC_PIN = 2'h0,
    TEC_SRC_TB2 = 2'h1,
    TEC_SRC_NEIGH = 2'h2
  } tec_src_t;

  typedef struct packed {
    logic [9:0] ctrl;
    logic [15:0] count;
    logic [15:0] reload;
    logic [1:0] status;
    logic [1:0] mask;
    logic port_out;
    logic port_oe;
    logic pulse;
    logic [2:0] in_sync;
    logic [2:0] dir_sync;
    logic in_prev;
    logic irq;
    logic pready;
    logic [31:0] prdata;
  } tec_state_t;
endpackage : tec_pkg

// ==== tb/tec_pulse_src.sv ====
module tec_pulse_src (
  input wire logic pclk,
  input wire logic [1:0] req,
  output logic pin,
  output logic b2_ovf,
  output logic nb_ovf
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pin = 1'b0;
    b2_ovf = 1'b0;
    nb_ovf = 1'b0;
  end
  // One-cycle overflow pulses, pin toggles on request
  always @(posedge pclk) begin
    b2_ovf <= (req == 2'h1);
    nb_ovf <= (req == 2'h2);
    if (req == 2'h3) pin <= ~pin;
  end
endmodule : tec_pulse_src

// ==== tb/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, pin, b2, nb, p_out, p_oe, ovf, irq, prev;
  logic [1:0] req = 2'h0;
  logic dir_drv = 1'b0;
  int mismatches = 0, cmp_count = 0, cyc = 0, ovf_n = 0;
  always #50 pclk = ~pclk;
  tec_pulse_src u_src (.pclk(pclk), .req(req), .pin(pin), .b2_ovf(b2), .nb_ovf(nb));
  tec_event_counter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_input_pin(pin), .timer_b2_ovf(b2),
    .neighbour_timer_channel_ovf(nb), .pulse_output_pin_in(p_oe ? p_out : dir_drv),
    .pulse_output_pin_out(p_out), .pulse_output_pin_oe(p_oe), .overflow_pulse(ovf),
    .irq(irq));
  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task tick(input logic [1:0] k, input int n);
    repeat (n) begin
      @(posedge pclk) req <= k;
      @(posedge pclk) req <= 2'h0;
    end
    repeat (6) @(posedge pclk);
  endtask : tick
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task t_reset;
    rd(12'h004, 32'h0000ffff);
    rd(12'h000, 32'h00000000);
    rd(12'hffc, 32'h00000000);
    $display("test reset done");
  endtask : t_reset
  task t_up_reload;
    apb(1'b1, 12'h004, 32'h0000fffd);
    rd(12'h004, 32'h0000fffd);
    apb(1'b1, 12'h00c, 32'h00000003);
    apb(1'b1, 12'h000, 32'h00000085);
    prev = p_out;
    tick(2'h1, 2);
    rd(12'h004, 32'h0000ffff);
    chk(irq, 1'b0);
    tick(2'h1, 1);
    rd(12'h004, 32'h0000fffd);
    rd(12'h008, 32'h00000001);
    chk(irq, 1'b1);
    chk(p_out, {31'h0, ~prev});
    apb(1'b1, 12'h004, 32'h00000010);
    rd(12'h004, 32'h0000fffd);
    apb(1'b1, 12'h008, 32'h00000003);
    @(posedge pclk);
    chk(irq, 1'b0);
    $display("test up reload done");
  endtask : t_up_reload
  task t_down_free;
    apb(1'b1, 12'h000, 32'h00000000);
    apb(1'b1, 12'h004, 32'h00000001);
    apb(1'b1, 12'h000, 32'h00000069);
    tick(2'h2, 1);
    rd(12'h004, 32'h00000000);
    tick(2'h2, 1);
    rd(12'h004, 32'h0000ffff);
    rd(12'h008, 32'h00000002);
    apb(1'b1, 12'h000, 32'h00000008);
    tick(2'h2, 2);
    rd(12'h004, 32'h0000ffff);
    chk(ovf_n, 32'h2);
    chk(pslverr, 32'h0);
    $display("test down free done");
  endtask : t_down_free
  task t_port_dir;
    apb(1'b1, 12'h010, 32'h00000003);
    repeat (2) @(posedge pclk);
    chk(p_out, 32'h1);
    chk(p_oe, 32'h1);
    rd(12'h010, 32'h00000003);
    dir_drv <= 1'b1;
    apb(1'b1, 12'h000, 32'h00000019);
    tick(2'h2, 1);
    rd(12'h004, 32'h00000005);
    $display("test port dir done");
  endtask : t_port_dir
  always @(posedge pclk) begin
    if (ovf === 1'b1) ovf_n <= ovf_n + 1;
  end
  task t_pin_edge;
    apb(1'b1, 12'h004, 32'h00000005);
    apb(1'b1, 12'h000, 32'h00000103);
    tick(2'h3, 1);
    rd(12'h004, 32'h00000005);
    tick(2'h3, 1);
    rd(12'h004, 32'h00000006);
    $display("test pin edge done");
  endtask : t_pin_edge
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      test_done;
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_up_reload;
    t_down_free;
    t_pin_edge;
    t_port_dir;
    test_done;
  end
endmodule : tb_top
